// ===== logic/iefr_regs.vh
// Register map, field positions and reset values of the interrupt and reset-cause block.
// Included by the top-level design file only; definitions only.
`ifndef IEFR_REGS_VH
`define IEFR_REGS_VH

`define IEFR_ADDR_W            8
`define IEFR_DATA_W            8
`define IEFR_OFF_IRQ_CTRL_LO   8'h0B
`define IEFR_OFF_IRQ_CTRL_HI   8'h8B
`define IEFR_OFF_PIR_FLAG      8'h0C
`define IEFR_OFF_PIR_ENABLE    8'h8C
`define IEFR_OFF_RESET_CAUSE   8'h8E

// Core control register fields
`define IEFR_BIT_GIE           7
`define IEFR_BIT_PGATE         6
`define IEFR_BIT_TOV_EN        5
`define IEFR_BIT_EXT_EN        4
`define IEFR_BIT_PCH_EN        3
`define IEFR_BIT_TOV_FLAG      2
`define IEFR_BIT_EXT_FLAG      1
`define IEFR_BIT_PCH_FLAG      0

// Peripheral registers: only the converter source is implemented
`define IEFR_BIT_CONV          6
`define IEFR_PIR_MASK          8'h40

// Reset-cause register fields
`define IEFR_BIT_PARITY_CFG    7
`define IEFR_BIT_PER           2
`define IEFR_BIT_POR           1
`define IEFR_BIT_BOR           0

`define IEFR_RST_IRQ_CTRL      8'h00
`define IEFR_RST_PIR_FLAG      8'h00
`define IEFR_RST_PIR_ENABLE    8'h00
// Reset-cause status bits after reset; brown-out has no defined value, zero chosen
`define IEFR_RST_PER           1'b1
`define IEFR_RST_POR           1'b0
`define IEFR_RST_BOR           1'b0

`endif

// ===== logic/iefr_flag_bit.v
// One sticky interrupt flag: set by a hardware event pulse, cleared by a software write.
// Assumes event and write pulses come from logic on core_clk.
module iefr_flag_bit (
  input  wire core_clk,
  input  wire rst_n,
  input  wire set_evt,
  input  wire wr_en,
  input  wire wr_val,
  output reg  flag_q
);

  // Set beats a simultaneous clearing write so no event is lost
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (wr_en) begin
      flag_q <= wr_val;
    end
  end

endmodule // iefr_flag_bit

// ===== logic/iefr_top.v
// Interrupt enable and flag registers, peripheral gate and reset-cause status.
// Assumes a CPU core on core_clk driving a single-cycle register port, and
// event pulses from peripherals on core_clk; reset sources arrive from pins
// or other domains and are synchronised here.
//
// Summary of operation
// - Core control register answers at both 0x0B and 0x8B.
// - Core control holds global, gate, and three source enables and flags.
// - Peripheral enable register at 0x8C holds the converter-complete enable.
// - Peripheral flags reach the CPU only while gate bit 6 is set.
// - Peripheral flag register at 0x0C holds peripheral source flags.
// - Flags set on their event regardless of own enable or global enable.
// - Reset-cause register at 0x8E distinguishes the reset kinds.
// - Bit 7 of reset-cause is read-only copy of parity-check config.
// - Brown-out bit reads zero after reset; cleared by brown-out reset.
// - Brown-out bit meaningless while brown-out detection is disabled.
// - Parity, power-on, brown-out bits clear on matching reset; software sets.
//
// Implementation choice: the address-and-strobe port.
`include "iefr_regs.vh"

module iefr_top (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       timer_ovf_evt,
  input  wire       ext_pin_evt,
  input  wire       port_change_evt,
  input  wire       conv_done_evt,
  input  wire       parity_check_cfg,
  input  wire       brownout_detect_config,
  input  wire       por_evt,
  input  wire       bor_evt,
  input  wire       per_evt,
  output wire       irq_req
);

  localparam NFLAG = 4;

  reg  [1:0] por_sync_q;
  reg  [1:0] bor_sync_q;
  reg  [1:0] per_sync_q;
  reg  [1:0] pcfg_sync_q;
  reg  [1:0] bcfg_sync_q;
  reg        por_seen_q;
  reg        bor_seen_q;
  reg        per_seen_q;
  reg        gie_q;
  reg        pgate_q;
  reg        tov_en_q;
  reg        ext_en_q;
  reg        pch_en_q;
  reg        conv_en_q;
  reg        per_stat_q;
  reg        por_stat_q;
  reg        bor_stat_q;
  wire       sel_ctrl;
  wire       sel_pflag;
  wire       sel_pen;
  wire       sel_rc;
  wire       wr_ctrl;
  wire       wr_pflag;
  wire       por_pulse;
  wire       bor_pulse;
  wire       per_pulse;
  wire [NFLAG-1:0] flag_set;
  wire [NFLAG-1:0] flag_wen;
  wire [NFLAG-1:0] flag_wval;
  wire [NFLAG-1:0] flag_q;
  wire       core_hit;
  wire       periph_hit;
  reg  [7:0] rd_mux;

  // Same register seen from either bank
  assign sel_ctrl  = (reg_addr == `IEFR_OFF_IRQ_CTRL_LO) ||
                     (reg_addr == `IEFR_OFF_IRQ_CTRL_HI);
  assign sel_pflag = (reg_addr == `IEFR_OFF_PIR_FLAG);
  assign sel_pen   = (reg_addr == `IEFR_OFF_PIR_ENABLE);
  assign sel_rc    = (reg_addr == `IEFR_OFF_RESET_CAUSE);
  assign wr_ctrl   = reg_wr && sel_ctrl;
  assign wr_pflag  = reg_wr && sel_pflag;

  // Reset sources are asynchronous to core_clk; two stages before use
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_sync_q  <= 2'b00;
      bor_sync_q  <= 2'b00;
      per_sync_q  <= 2'b00;
      pcfg_sync_q <= 2'b00;
      bcfg_sync_q <= 2'b00;
      por_seen_q  <= 1'b0;
      bor_seen_q  <= 1'b0;
      per_seen_q  <= 1'b0;
    end else begin
      por_sync_q  <= {por_sync_q[0], por_evt};
      bor_sync_q  <= {bor_sync_q[0], bor_evt};
      per_sync_q  <= {per_sync_q[0], per_evt};
      pcfg_sync_q <= {pcfg_sync_q[0], parity_check_cfg};
      bcfg_sync_q <= {bcfg_sync_q[0], brownout_detect_config};
      por_seen_q  <= por_sync_q[1];
      bor_seen_q  <= bor_sync_q[1];
      per_seen_q  <= per_sync_q[1];
    end
  end

  assign por_pulse = por_sync_q[1] && !por_seen_q;
  // With detection disabled the brown-out indication is not acted on
  assign bor_pulse = bor_sync_q[1] && !bor_seen_q && bcfg_sync_q[1];
  assign per_pulse = per_sync_q[1] && !per_seen_q;

  // Flag order: 0 port change, 1 ext pin, 2 timer overflow, 3 converter
  assign flag_set  = {conv_done_evt, timer_ovf_evt, ext_pin_evt, port_change_evt};
  assign flag_wen  = {wr_pflag, wr_ctrl, wr_ctrl, wr_ctrl};
  assign flag_wval = {reg_wdata[`IEFR_BIT_CONV], reg_wdata[`IEFR_BIT_TOV_FLAG],
                      reg_wdata[`IEFR_BIT_EXT_FLAG], reg_wdata[`IEFR_BIT_PCH_FLAG]};

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
      iefr_flag_bit u_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_evt  (flag_set[gi]),
        .wr_en    (flag_wen[gi]),
        .wr_val   (flag_wval[gi]),
        .flag_q   (flag_q[gi])
      );
    end
  endgenerate

  // Enable bits of the core control and peripheral enable registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q     <= 1'b0;
      pgate_q   <= 1'b0;
      tov_en_q  <= 1'b0;
      ext_en_q  <= 1'b0;
      pch_en_q  <= 1'b0;
      conv_en_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        gie_q    <= reg_wdata[`IEFR_BIT_GIE];
        pgate_q  <= reg_wdata[`IEFR_BIT_PGATE];
        tov_en_q <= reg_wdata[`IEFR_BIT_TOV_EN];
        ext_en_q <= reg_wdata[`IEFR_BIT_EXT_EN];
        pch_en_q <= reg_wdata[`IEFR_BIT_PCH_EN];
      end
      if (reg_wr && sel_pen) begin
        conv_en_q <= reg_wdata[`IEFR_BIT_CONV];
      end
    end
  end

  // Status bits: the matching reset clears, software sets; the clear wins
  // here because a reset event must always be recorded. The brown-out bit
  // is zero after reset until software sets it.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_stat_q <= `IEFR_RST_PER;
      por_stat_q <= `IEFR_RST_POR;
      bor_stat_q <= `IEFR_RST_BOR;
    end else begin
      if (per_pulse) begin
        per_stat_q <= 1'b0;
      end else if (reg_wr && sel_rc) begin
        per_stat_q <= reg_wdata[`IEFR_BIT_PER];
      end
      if (por_pulse) begin
        por_stat_q <= 1'b0;
      end else if (reg_wr && sel_rc) begin
        por_stat_q <= reg_wdata[`IEFR_BIT_POR];
      end
      if (bor_pulse) begin
        bor_stat_q <= 1'b0;
      end else if (reg_wr && sel_rc) begin
        bor_stat_q <= reg_wdata[`IEFR_BIT_BOR];
      end
    end
  end

  // Combined request to the CPU
  assign core_hit   = (tov_en_q && flag_q[2]) || (ext_en_q && flag_q[1]) ||
                      (pch_en_q && flag_q[0]);
  assign periph_hit = pgate_q && conv_en_q && flag_q[3];
  assign irq_req    = gie_q && (core_hit || periph_hit);

  always @* begin
    rd_mux = 8'h00;
    if (sel_ctrl) begin
      rd_mux = {gie_q, pgate_q, tov_en_q, ext_en_q, pch_en_q,
                flag_q[2], flag_q[1], flag_q[0]};
    end else if (sel_pflag) begin
      rd_mux = {1'b0, flag_q[3], 6'h00};
    end else if (sel_pen) begin
      rd_mux = {1'b0, conv_en_q, 6'h00};
    end else if (sel_rc) begin
      // Bit 7 is a read-only view of the configuration word
      rd_mux = {pcfg_sync_q[1], 4'h0, per_stat_q, por_stat_q, bor_stat_q};
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // iefr_top

// ===== bench/iefr_chk.sv
// Checker bound to iefr_top: register map, flag, request and reset-cause relations.
// Assumes one-cycle strobes and read data in the cycle after the read strobe.
module iefr_chk (
  input logic       core_clk,
  input logic       rst_n,
  input logic [7:0] reg_addr,
  input logic       reg_rd,
  input logic       reg_wr,
  input logic [7:0] reg_rdata,
  input logic       timer_ovf_evt,
  input logic       ext_pin_evt,
  input logic       port_change_evt,
  input logic       conv_done_evt,
  input logic       parity_check_cfg,
  input logic       por_evt,
  input logic       irq_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire ctl_rd = reg_rd && (reg_addr == 8'h0B || reg_addr == 8'h8B);
  wire rc_rd  = reg_rd && reg_addr == 8'h8E;
  wire pf_rd  = reg_rd && (reg_addr == 8'h0C || reg_addr == 8'h8C);
  wire evt    = timer_ovf_evt || ext_pin_evt || port_change_evt;
  wire cause  = evt || conv_done_evt || reg_wr;
  property p_unmapped; reg_rd && !ctl_rd && !rc_rd && !pf_rd |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_periph; pf_rd |=> (reg_rdata & 8'hBF) == 8'h00; endproperty
  a_periph: assert property (p_periph) else $error("peripheral spare bits");
  property p_cause; rc_rd |=> reg_rdata[6:3] == 4'h0; endproperty
  a_cause: assert property (p_cause) else $error("reset-cause spare bits");
  property p_cfg; parity_check_cfg [*4] ##0 rc_rd |=> reg_rdata[7]; endproperty
  a_cfg: assert property (p_cfg) else $error("config mirror low");
  property p_flag; timer_ovf_evt ##1 ctl_rd |=> reg_rdata[2]; endproperty
  a_flag: assert property (p_flag) else $error("timer flag not set");
  property p_keep; ctl_rd ##1 (ctl_rd && reg_rdata[2]) |=> reg_rdata[2]; endproperty
  a_keep: assert property (p_keep) else $error("timer flag lost");
  property p_alias; (ctl_rd && !evt) ##1 ctl_rd |=> reg_rdata == $past(reg_rdata); endproperty
  a_alias: assert property (p_alias) else $error("control aliases differ");
  property p_irq; $rose(irq_req) |-> $past(cause); endproperty
  a_irq: assert property (p_irq) else $error("request rose without cause");
  property p_por; $rose(por_evt) ##8 rc_rd |=> !reg_rdata[1]; endproperty
  a_por: assert property (p_por) else $error("power-on bit not cleared");
endmodule // iefr_chk

bind iefr_top iefr_chk u_chk (.*);

// ===== bench/iefr_far_model.sv
// Far side: peripheral event sources and the reset generator.
// Assumes the bench asks for each event as a one-cycle request.
module iefr_far_model (
  input  logic       rst_n,
  input  logic [3:0] fire,
  input  logic [2:0] rst_req,
  output logic       timer_ovf_evt,
  output logic       ext_pin_evt,
  output logic       port_change_evt,
  output logic       conv_done_evt,
  output logic       por_evt,
  output logic       bor_evt,
  output logic       per_evt
);
  timeunit 1ns;
  timeprecision 100ps;
  // Peripheral event sources stay quiet while the core is held in reset; reset requests pass through
  assign {conv_done_evt, port_change_evt, ext_pin_evt, timer_ovf_evt} = fire & {4{rst_n}};
  assign {per_evt, bor_evt, por_evt} = rst_req;
endmodule // iefr_far_model

// ===== bench/tb_irq_enable_flags_reset_cause.sv
// Bench for iefr_top: register table, then events, gating, reset causes, mid-run reset.
// Far-side model supplies event pulses and reset-generator levels.
module tb_irq_enable_flags_reset_cause;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] fire = 4'h0;
  logic [2:0] rst_req = 3'h0;
  logic       parity_check_cfg = 1'b1;
  logic       brownout_detect_config = 1'b1;
  logic       irq_req, timer_ovf_evt, ext_pin_evt, port_change_evt;
  logic       conv_done_evt, por_evt, bor_evt, per_evt;
  int         error_cnt = 0;
  int         n_tests = 0;
  // Write address, write data, read address, expected read data
  logic [31:0] rows [10] = '{32'h0B38_8B38, 32'h8B07_0B07, 32'h8CFF_8C40, 32'h0CFF_0C40,
    32'h8E00_8E80, 32'h8EFF_8E87, 32'h55FF_5500, 32'h0C00_0C00, 32'h8C00_8C00, 32'h0B00_8B00};
  logic [7:0]  rc_exp [3] = '{8'h85, 8'h86, 8'h83};
  iefr_top dut_u (.*);
  iefr_far_model far_u (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic ev(input logic [3:0] f);
    fire <= f;
    @(posedge core_clk);
    fire <= 4'h0;
    #1;
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][15:8], rows[i][7:0]);
    end
    ev(4'h1);
    rd(8'h0B, 8'h04);
    ev(4'hE);
    rd(8'h8B, 8'h07);
    rd(8'h0B, 8'h07);
    rd(8'h0C, 8'h40);
    chk({7'h00, irq_req}, 8'h00);
    wr(8'h0B, 8'h00);
    wr(8'h0C, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h0B, 8'h80 | (8'h20 >> i));
      ev(4'h7 & ~(4'h1 << i));
      chk({7'h00, irq_req}, 8'h00);
      ev(4'h1 << i);
      chk({7'h00, irq_req}, 8'h01);
      wr(8'h0B, 8'h00);
    end
    wr(8'h8C, 8'h40);
    ev(4'h8);
    wr(8'h0B, 8'h80);
    chk({7'h00, irq_req}, 8'h00);
    wr(8'h0B, 8'hC0);
    chk({7'h00, irq_req}, 8'h01);
    wr(8'h0B, 8'h40);
    chk({7'h00, irq_req}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h8E, 8'h07);
      rst_req[i] <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(8'h8E, rc_exp[i]);
      rst_req <= 3'h0;
    end
    wr(8'h0B, 8'hFF);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({7'h00, irq_req}, 8'h00);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rd(8'h8B, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h8E, 8'h84);
    print_verdict;
  end
endmodule // tb_irq_enable_flags_reset_cause
